// *** wdcfg_top.sv ***
// Watchdog configuration word, clock select and windowed watchdog timer
// ============================================================
// Summary of operation
// RULE_01 - Select 11 with mux: low-power RC always
// RULE_02 - Select 10: fast RC if windowed, awake; the code also requires sysClkIsLowRc low, else low-power RC
// RULE_03 - Select 01: secondary oscillator always
// RULE_04 - Select 00: peripheral clock unless asleep or slow
// RULE_05 - Mux bit 0 forces low-power RC
// RULE_06 - Window width 25/37.5/50/75 percent of period
// RULE_07 - Window disable bit 1 turns windowing off
// RULE_08 - Enable 10: software bit decides running
// RULE_09 - Enable 01: run awake only, ignore software
// RULE_10 - Enable 11 always on, 00 all off
// RULE_11 - Prescaler divides by 128 or 32
// RULE_12 - Unimplemented word bits read as one
// RULE_13 - Fields read, reset to one, program once
// RULE_14 - Postscaler 2^n further divides the timeout
// RULE_15 - Early clear in windowed mode is a fault
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "wdcfg_cfg.svh"
`default_nettype none
module wdcfg_top #(
  parameter int POST_MAX = 15
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [23:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output var  logic [23:0] regRdata,
  input  wire logic        sysClkIsLowRc,
  input  wire logic        sleeping,
  input  wire logic        wdClear,
  output var  logic [3:0]  wdSrc,
  output var  logic        wdRunning,
  output var  logic        wdTimeout,
  output var  logic        wdEarlyFault
);
  // ============================================================
  // Reset release and input synchronisers
  logic rstMeta_q, rstSync_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstN = rstSync_q;

  wdcfg_pkg::wdcfg_sys_type sysMeta_q, sys_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sysMeta_q <= '0;
      sys_q     <= '0;
    end else begin
      sysMeta_q <= '{sysClkIsLowRc: sysClkIsLowRc, sleeping: sleeping};
      sys_q     <= sysMeta_q;
    end
  end

  // ============================================================
  // Configuration word, programmed once as a whole word
  logic [23:0] word_q;
  logic        progDone_q;
  logic        swEn_q;
  wire wordWr = regWrite && (regAddr == `WDCFG_WORD_ADDR);
  wire ctrlWr = regWrite && (regAddr == `WDCFG_CTRL_ADDR);
  // Only the first write lands; later writes are ignored [RULE_13]
  wire [23:0] wordD = progDone_q ? word_q : (regWdata | `WDCFG_UNIMPL_MASK); // [RULE_12]
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      word_q     <= `WDCFG_WORD_RESET; // [RULE_13]
      progDone_q <= 1'b0;
      swEn_q     <= 1'b0;
    end else begin
      if (wordWr) word_q <= wordD;
      if (wordWr) progDone_q <= 1'b1;
      if (ctrlWr) swEn_q <= regWdata[0];
    end
  end

  wdcfg_pkg::wdcfg_fields_type f;
  assign f.clkSel   = word_q[`WDCFG_POS_CLK +: 2];
  assign f.muxEn    = word_q[`WDCFG_POS_CMX];
  assign f.winWidth = word_q[`WDCFG_POS_WIN +: 2];
  assign f.window_mode_disable   = word_q[`WDCFG_POS_WINOFF];
  assign f.enMode   = word_q[`WDCFG_POS_EN +: 2];
  assign f.preSel   = word_q[`WDCFG_POS_PSA];
  assign f.postSel  = word_q[`WDCFG_POS_PS +: 4];

  // ============================================================
  // Clock source selection
  wire awakeFast = !sys_q.sysClkIsLowRc && !sys_q.sleeping;
  wdcfg_pkg::wdcfg_src_type srcD;
  always_comb begin
    srcD = wdcfg_pkg::SRC_LOWRC; // [RULE_05]
    if (f.muxEn) begin
      unique case (f.clkSel)
        2'h3: srcD = wdcfg_pkg::SRC_LOWRC; // [RULE_01]
        2'h2: srcD = (!f.window_mode_disable && awakeFast) ? wdcfg_pkg::SRC_FASTRC
                                              : wdcfg_pkg::SRC_LOWRC; // [RULE_02]
        2'h1: srcD = wdcfg_pkg::SRC_SECOSC; // [RULE_03]
        2'h0: srcD = awakeFast ? wdcfg_pkg::SRC_PER : wdcfg_pkg::SRC_LOWRC; // [RULE_04]
      endcase
    end
  end

  // ============================================================
  // Enable decode
  logic runD;
  always_comb begin
    unique case (f.enMode)
      2'h3: runD = 1'b1;            // [RULE_10]
      2'h2: runD = swEn_q;          // [RULE_08]
      2'h1: runD = !sys_q.sleeping; // [RULE_09]
      2'h0: runD = 1'b0;            // [RULE_10]
    endcase
  end

  // ============================================================
  // Timer: prescaler then 2^postN postscaler (postSel capped at POST_MAX), counted on clk ticks
  logic [7:0]  pre_q;
  logic [15:0] post_q;
  wire [7:0]  preLim  = f.preSel ? `WDCFG_PRE_LONG : `WDCFG_PRE_SHORT; // [RULE_11]
  wire [2:0]  preShift = f.preSel ? `WDCFG_PRE_SHIFT_LONG : `WDCFG_PRE_SHIFT_SHORT;
  wire        preTick = (pre_q == preLim - 8'h01);
  wire [3:0]  postN   = (f.postSel > POST_MAX[3:0]) ? POST_MAX[3:0] : f.postSel;
  wire [15:0] period  = 16'h0001 << postN; // [RULE_14]
  // Window edges are compared in clk ticks so that 37.5% stays exact
  wire [23:0] total   = 24'(period) << preShift;
  wire [23:0] elapsed = (24'(post_q) << preShift) | 24'(pre_q);
  // Window opens once the open fraction remains: 75% window opens at 1/4
  logic [23:0] openAt;
  always_comb begin
    unique case (f.winWidth)
      2'h3: openAt = total - (total >> 2);                // [RULE_06]
      2'h2: openAt = total - (total >> 2) - (total >> 3); // [RULE_06]
      2'h1: openAt = total >> 1;                          // [RULE_06]
      2'h0: openAt = total >> 2;                          // [RULE_06]
    endcase
  end
  wire windowed = !f.window_mode_disable; // [RULE_07]
  wire early    = wdClear && windowed && (elapsed < openAt); // [RULE_15]
  wire expire   = preTick && (post_q == period - 16'h0001);

  logic fault_q, tout_q;
  // A new word restarts the count, so old counts never overrun new limits
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pre_q   <= 8'h00;
      post_q  <= 16'h0000;
      fault_q <= 1'b0;
      tout_q  <= 1'b0;
    end else begin
      pre_q   <= (!runD || wdClear || wordWr || preTick) ? 8'h00 : pre_q + 8'h01;
      post_q  <= (!runD || wdClear || wordWr || expire) ? 16'h0000
               : (preTick ? post_q + 16'h0001 : post_q);
      fault_q <= runD && early;
      tout_q  <= runD && expire && !wdClear;
    end
  end

  // ============================================================
  // Register read and outputs
  wire [23:0] rdSel = (regAddr == `WDCFG_WORD_ADDR) ? word_q
                    : (regAddr == `WDCFG_CTRL_ADDR) ? {23'h000000, swEn_q}
                    : (regAddr == `WDCFG_STAT_ADDR) ? {18'h00000, progDone_q, runD, srcD}
                    : 24'h000000;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata     <= 24'h000000;
      wdSrc        <= wdcfg_pkg::SRC_LOWRC;
      wdRunning    <= 1'b0;
      wdTimeout    <= 1'b0;
      wdEarlyFault <= 1'b0;
    end else begin
      regRdata     <= regRead ? rdSel : 24'h000000;
      wdSrc        <= srcD;
      wdRunning    <= runD;
      wdTimeout    <= tout_q;
      wdEarlyFault <= fault_q;
    end
  end

  // ============================================================
  // Checks
  a_unimpl_ones: assert property (@(posedge clk) disable iff (!rstN)
    (word_q & `WDCFG_UNIMPL_MASK) == `WDCFG_UNIMPL_MASK) // [RULE_12]
    else $error("unimplemented bit reads zero");
  a_once_only: assert property (@(posedge clk) disable iff (!rstN)
    progDone_q |=> $stable(word_q)) // [RULE_13]
    else $error("word changed after programming");
  a_mux_off_low_power_rc_osc: assert property (@(posedge clk) disable iff (!rstN) // [RULE_05]
    !f.muxEn |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("mux off but not low-power RC");
  a_secondary_osc_sel: assert property (@(posedge clk) disable iff (!rstN) // [RULE_03]
    (f.muxEn && f.clkSel == 2'h1) |=> wdSrc == wdcfg_pkg::SRC_SECOSC)
    else $error("secondary oscillator not chosen");
  a_sel11_low_power_rc_osc: assert property (@(posedge clk) disable iff (!rstN) // [RULE_01]
    (f.muxEn && f.clkSel == 2'h3) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("select 11 not low-power RC");
  a_frc_sel: assert property (@(posedge clk) disable iff (!rstN) // [RULE_02]
    (f.muxEn && f.clkSel == 2'h2 && f.window_mode_disable) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("fast RC without windowing");
  a_per_sel: assert property (@(posedge clk) disable iff (!rstN) // [RULE_04]
    (f.muxEn && f.clkSel == 2'h0 && sys_q.sleeping) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("peripheral clock while sleeping");
  a_off_mode: assert property (@(posedge clk) disable iff (!rstN)
    (f.enMode == 2'h0) |=> !wdRunning) // [RULE_10]
    else $error("watchdog runs in off mode");
  a_active_only: assert property (@(posedge clk) disable iff (!rstN)
    (f.enMode == 2'h1) |=> wdRunning == !$past(sys_q.sleeping)) // [RULE_09]
    else $error("active-only mode wrong");
  a_sw_mode: assert property (@(posedge clk) disable iff (!rstN)
    (f.enMode == 2'h2) |=> wdRunning == $past(swEn_q)) // [RULE_08]
    else $error("software enable ignored");
  a_pre_limit: assert property (@(posedge clk) disable iff (!rstN)
    pre_q < preLim) // [RULE_11]
    else $error("prescaler overran ratio");
  a_early_fault: assert property (@(posedge clk) disable iff (!rstN)
    (runD && early) |-> ##2 wdEarlyFault) // [RULE_15]
    else $error("early clear not flagged");
  a_nowin_nofault: assert property (@(posedge clk) disable iff (!rstN)
    f.window_mode_disable |-> !early) // [RULE_07]
    else $error("fault with windowing off");

  // ============================================================
  // Source and enable checks
  a_frc_pick: assert property (@(posedge clk) disable iff (!rstN) // [RULE_02]
    (f.muxEn && f.clkSel == 2'h2 && !f.window_mode_disable && awakeFast) |=> wdSrc == wdcfg_pkg::SRC_FASTRC)
    else $error("fast RC not chosen");
  a_frc_sys: assert property (@(posedge clk) disable iff (!rstN) // [RULE_02]
    (f.muxEn && f.clkSel == 2'h2 && sys_q.sysClkIsLowRc) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("fast RC on slow system clock");
  a_frc_sleep: assert property (@(posedge clk) disable iff (!rstN) // [RULE_02]
    (f.muxEn && f.clkSel == 2'h2 && sys_q.sleeping) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("fast RC while sleeping");
  a_per_pick: assert property (@(posedge clk) disable iff (!rstN) // [RULE_04]
    (f.muxEn && f.clkSel == 2'h0 && awakeFast) |=> wdSrc == wdcfg_pkg::SRC_PER)
    else $error("peripheral clock not chosen");
  a_per_sys: assert property (@(posedge clk) disable iff (!rstN) // [RULE_04]
    (f.muxEn && f.clkSel == 2'h0 && sys_q.sysClkIsLowRc) |=> wdSrc == wdcfg_pkg::SRC_LOWRC)
    else $error("peripheral clock on slow system clock");
  a_secondary_osc_sleep: assert property (@(posedge clk) disable iff (!rstN) // [RULE_03]
    (f.muxEn && f.clkSel == 2'h1 && sys_q.sleeping) |=> wdSrc == wdcfg_pkg::SRC_SECOSC)
    else $error("secondary oscillator lost in sleep");
  a_src_onehot: assert property (@(posedge clk) disable iff (!rstN) // [RULE_05]
    $onehot(wdSrc))
    else $error("source indicator not one-hot");
  a_always_on: assert property (@(posedge clk) disable iff (!rstN) // [RULE_10]
    (f.enMode == 2'h3) |=> wdRunning)
    else $error("always-on mode stopped");
  a_active_sleep: assert property (@(posedge clk) disable iff (!rstN) // [RULE_09]
    (f.enMode == 2'h1 && sys_q.sleeping) |=> !wdRunning)
    else $error("active-only mode runs in sleep");
  a_active_swoff: assert property (@(posedge clk) disable iff (!rstN) // [RULE_09]
    (f.enMode == 2'h1 && !sys_q.sleeping && !swEn_q) |=> wdRunning)
    else $error("active-only mode obeys software bit");
  a_sw_on: assert property (@(posedge clk) disable iff (!rstN) // [RULE_08]
    (f.enMode == 2'h2 && swEn_q) |=> wdRunning)
    else $error("software enable did not start");
  a_sw_off: assert property (@(posedge clk) disable iff (!rstN) // [RULE_08]
    (f.enMode == 2'h2 && !swEn_q) |=> !wdRunning)
    else $error("software disable did not stop");

  // ============================================================
  // Counter and window checks
  sequence s_clearEarly;
    runD && early;
  endsequence
  sequence s_expireTick;
    runD && expire && !wdClear;
  endsequence
  sequence s_countFree;
    runD && !wdClear && !wordWr;
  endsequence
  a_pre_step: assert property (@(posedge clk) disable iff (!rstN) // [RULE_11]
    (s_countFree ##0 !preTick) |=> pre_q == $past(pre_q) + 8'h01)
    else $error("prescaler did not step");
  a_pre_wrap: assert property (@(posedge clk) disable iff (!rstN) // [RULE_11]
    (s_countFree ##0 preTick) |=> pre_q == 8'h00)
    else $error("prescaler did not wrap");
  a_post_step: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    (s_countFree ##0 (preTick && !expire)) |=> post_q == $past(post_q) + 16'h0001)
    else $error("postscaler did not step");
  a_post_hold: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    (s_countFree ##0 !preTick) |=> $stable(post_q))
    else $error("postscaler moved between ticks");
  a_post_wrap: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    (s_countFree ##0 expire) |=> post_q == 16'h0000)
    else $error("postscaler did not wrap");
  a_post_limit: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    post_q < period)
    else $error("postscaler overran period");
  a_stop_idle: assert property (@(posedge clk) disable iff (!rstN) // [RULE_10]
    !runD |=> (pre_q == 8'h00 && post_q == 16'h0000))
    else $error("stopped watchdog still counts");
  a_clear_restart: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    (runD && wdClear) |=> (pre_q == 8'h00 && post_q == 16'h0000))
    else $error("clear did not restart count");
  a_timeout_due: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    s_expireTick |-> ##2 wdTimeout)
    else $error("timeout not flagged");
  a_timeout_only: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    !(runD && expire && !wdClear) |-> ##2 !wdTimeout)
    else $error("spurious timeout");
  a_timeout_pulse: assert property (@(posedge clk) disable iff (!rstN) // [RULE_14]
    wdTimeout |=> !wdTimeout)
    else $error("timeout longer than one cycle");
  a_fault_only: assert property (@(posedge clk) disable iff (!rstN) // [RULE_15]
    !(runD && early) |-> ##2 !wdEarlyFault)
    else $error("spurious early fault");
  a_late_clear: assert property (@(posedge clk) disable iff (!rstN) // [RULE_15]
    (wdClear && elapsed >= openAt) |-> ##2 !wdEarlyFault)
    else $error("clear in open window flagged");
  a_fault_win: assert property (@(posedge clk) disable iff (!rstN) // [RULE_07]
    s_clearEarly |-> !f.window_mode_disable)
    else $error("early clear with windowing off");
  a_open_25: assert property (@(posedge clk) disable iff (!rstN) // [RULE_06]
    (f.winWidth == 2'h3) |-> ({2'h0, openAt} * 26'h4 == {2'h0, total} * 26'h3))
    else $error("25 percent window wrong");
  a_open_375: assert property (@(posedge clk) disable iff (!rstN) // [RULE_06]
    (f.winWidth == 2'h2) |-> ({2'h0, openAt} * 26'h8 == {2'h0, total} * 26'h5))
    else $error("37.5 percent window wrong");
  a_open_50: assert property (@(posedge clk) disable iff (!rstN) // [RULE_06]
    (f.winWidth == 2'h1) |-> ({2'h0, openAt} * 26'h2 == {2'h0, total}))
    else $error("50 percent window wrong");
  a_open_75: assert property (@(posedge clk) disable iff (!rstN) // [RULE_06]
    (f.winWidth == 2'h0) |-> ({2'h0, openAt} * 26'h4 == {2'h0, total}))
    else $error("75 percent window wrong");

  // ============================================================
  // Register port checks
  a_rd_idle: assert property (@(posedge clk) disable iff (!rstN) // [RULE_13]
    !regRead |=> regRdata == 24'h000000)
    else $error("read data without read");
  a_rd_word: assert property (@(posedge clk) disable iff (!rstN) // [RULE_13]
    (regRead && regAddr == `WDCFG_WORD_ADDR) |=> regRdata == $past(word_q))
    else $error("word read wrong");
  a_rd_ctrl: assert property (@(posedge clk) disable iff (!rstN) // [RULE_08]
    (regRead && regAddr == `WDCFG_CTRL_ADDR) |=> regRdata == {23'h000000, $past(swEn_q)})
    else $error("control read wrong");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!rstN) // [RULE_13]
    (regRead && regAddr > `WDCFG_STAT_ADDR) |=> regRdata == 24'h000000)
    else $error("unmapped read not zero");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rstN) // [RULE_08]
    ctrlWr |=> swEn_q == $past(regWdata[0]))
    else $error("software enable not written");
  a_first_write: assert property (@(posedge clk) disable iff (!rstN) // [RULE_13]
    (wordWr && !progDone_q) |=> word_q == ($past(regWdata) | `WDCFG_UNIMPL_MASK))
    else $error("first word write lost");
  a_prog_flag: assert property (@(posedge clk) disable iff (!rstN) // [RULE_13]
    wordWr |=> progDone_q)
    else $error("programmed flag not set");
endmodule : wdcfg_top
`default_nettype wire

// *** wdcfg_cfg.svh ***
// Constants for the watchdog configuration word block
`ifndef WDCFG_CFG_SVH
`define WDCFG_CFG_SVH
`define WDCFG_WORD_ADDR     4'h0
`define WDCFG_CTRL_ADDR     4'h1
`define WDCFG_STAT_ADDR     4'h2
`define WDCFG_WORD_RESET    24'hffffff
`define WDCFG_UNIMPL_MASK   24'hff9400
`define WDCFG_POS_PS        0
`define WDCFG_POS_PSA       4
`define WDCFG_POS_EN        5
`define WDCFG_POS_WINOFF    7
`define WDCFG_POS_WIN       8
`define WDCFG_POS_CMX       11
`define WDCFG_POS_CLK       13
`define WDCFG_PRE_SHORT     8'h20
`define WDCFG_PRE_LONG      8'h80
`define WDCFG_PRE_SHIFT_SHORT 3'h5
`define WDCFG_PRE_SHIFT_LONG  3'h7
`endif

// *** wdcfg_pkg.sv ***
// Types for the watchdog configuration word block
`default_nettype none
package wdcfg_pkg;
  typedef enum logic [3:0] {
    SRC_LOWRC  = 4'h1,
    SRC_FASTRC = 4'h2,
    SRC_SECOSC = 4'h4,
    SRC_PER    = 4'h8
  } wdcfg_src_type;
  typedef struct packed {
    logic [1:0] clkSel;
    logic       muxEn;
    logic [1:0] winWidth;
    logic       window_mode_disable;
    logic [1:0] enMode;
    logic       preSel;
    logic [3:0] postSel;
  } wdcfg_fields_type;
  typedef struct packed {
    logic       sysClkIsLowRc;
    logic       sleeping;
  } wdcfg_sys_type;
endpackage : wdcfg_pkg
`default_nettype wire

// *** wdcfg_tb.sv ***
// Self-checking testbench for the watchdog configuration word block
`include "wdcfg_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [3:0]  regAddr = 4'h0;
  logic [23:0] regWdata = 24'h0;
  logic        regWrite = 1'h0;
  logic        regRead = 1'h0;
  logic [23:0] regRdata;
  logic        sysClkIsLowRc = 1'h0;
  logic        sleeping = 1'h0;
  logic        wdClear = 1'h0;
  logic [3:0]  wdSrc;
  logic        wdRunning;
  logic        wdTimeout;
  logic        wdEarlyFault;
  int          errors = 0;
  int          checks = 0;
  // Short postscaler cap keeps timeout runs to a few hundred cycles
  wdcfg_top #(.POST_MAX(2)) u_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .sysClkIsLowRc(sysClkIsLowRc), .sleeping(sleeping), .wdClear(wdClear), .wdSrc(wdSrc),
    .wdRunning(wdRunning), .wdTimeout(wdTimeout), .wdEarlyFault(wdEarlyFault));
  initial begin
    forever #25 clk = ~clk;
  end
  // ============================================================
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  function automatic logic [23:0] mk(input logic [1:0] cs, input logic mx, input logic [1:0] ww,
      input logic wd, input logic [1:0] en, input logic ps, input logic [3:0] po);
    mk = (24'(cs) << `WDCFG_POS_CLK) | (24'(mx) << `WDCFG_POS_CMX) | (24'(ww) << `WDCFG_POS_WIN)
       | (24'(wd) << `WDCFG_POS_WINOFF) | (24'(en) << `WDCFG_POS_EN)
       | (24'(ps) << `WDCFG_POS_PSA) | 24'(po);
  endfunction : mk
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [23:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1;
    chk(regRdata, exp);
  endtask : rdc
  task automatic boot(input logic [23:0] w);
    reset_n <= 1'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    if (w !== 24'h0) wr(4'h0, w);
  endtask : boot
  task automatic pulse;
    @(posedge clk);
    wdClear <= 1'h1;
    @(posedge clk);
    wdClear <= 1'h0;
  endtask : pulse
  task automatic wait_to(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (wdTimeout !== 1'h1 && n < 2000);
    if (n >= 2000) begin
      errors++;
      $display("BAD %0t timeout pulse missing", $time);
      end_of_test();
    end
  endtask : wait_to
  // ============================================================
  // Scenarios
  task automatic cfg(input logic [1:0] cs, input logic mx, input logic wd, input logic [1:0] en,
      input logic lp, input logic sl, input logic sw, input logic [3:0] src, input logic run);
    boot(mk(cs, mx, 2'h3, wd, en, 1'h0, 4'h0));
    sysClkIsLowRc <= lp;
    sleeping <= sl;
    wr(4'h1, {23'h0, sw});
    repeat (8) @(posedge clk);
    #1;
    chk({20'h0, wdSrc}, {20'h0, src});
    chk({23'h0, wdRunning}, {23'h0, run});
    rdc(4'h2, {18'h0, 1'h1, run, src});
    sysClkIsLowRc <= 1'h0;
    sleeping <= 1'h0;
    $display("clock and enable case done");
  endtask : cfg
  task automatic per(input logic ps, input logic [3:0] po, input int exp);
    int n;
    boot(mk(2'h3, 1'h1, 2'h3, 1'h1, 2'h3, ps, po));
    wait_to(n);
    wait_to(n);
    chk(24'(n), 24'(exp));
    $display("timeout period case done");
  endtask : per
  task automatic win(input logic [1:0] ww, input int dly, input logic ef);
    int n;
    logic f;
    boot(mk(2'h3, 1'h1, ww, 1'h0, 2'h3, 1'h0, 4'h2));
    wait_to(n);
    pulse();
    repeat (dly) @(posedge clk);
    pulse();
    f = 1'h0;
    repeat (6) begin
      @(posedge clk);
      #1;
      f |= wdEarlyFault;
    end
    chk(24'(f), 24'(ef));
    $display("window case done");
  endtask : win
  // ============================================================
  // Main sequence
  initial begin
    int op[4] = '{32, 64, 80, 96};
    logic [23:0] w;
    boot(24'h0);
    rdc(4'h0, `WDCFG_WORD_RESET);
    rdc(4'hf, 24'h0);
    repeat (6) @(posedge clk);
    #1;
    chk({20'h0, wdSrc}, 24'(wdcfg_pkg::SRC_LOWRC));
    chk({23'h0, wdRunning}, 24'h1);
    $display("reset default case done");
    w = mk(2'h0, 1'h1, 2'h1, 1'h1, 2'h2, 1'h0, 4'h5);
    boot(w);
    rdc(4'h0, w | `WDCFG_UNIMPL_MASK);
    wr(4'h0, 24'h0);
    rdc(4'h0, w | `WDCFG_UNIMPL_MASK);
    cfg(2'h3, 1'h1, 1'h1, 2'h3, 1'h0, 1'h0, 1'h0, 4'h1, 1'h1);
    cfg(2'h2, 1'h1, 1'h0, 2'h3, 1'h0, 1'h0, 1'h0, 4'h2, 1'h1);
    cfg(2'h2, 1'h1, 1'h1, 2'h3, 1'h0, 1'h0, 1'h0, 4'h1, 1'h1);
    cfg(2'h2, 1'h1, 1'h0, 2'h3, 1'h1, 1'h0, 1'h0, 4'h1, 1'h1);
    cfg(2'h2, 1'h1, 1'h0, 2'h3, 1'h0, 1'h1, 1'h0, 4'h1, 1'h1);
    cfg(2'h1, 1'h1, 1'h1, 2'h3, 1'h1, 1'h1, 1'h0, 4'h4, 1'h1);
    cfg(2'h0, 1'h1, 1'h1, 2'h1, 1'h0, 1'h0, 1'h1, 4'h8, 1'h1);
    cfg(2'h0, 1'h1, 1'h1, 2'h1, 1'h0, 1'h1, 1'h1, 4'h1, 1'h0);
    cfg(2'h0, 1'h1, 1'h1, 2'h1, 1'h1, 1'h0, 1'h0, 4'h1, 1'h1);
    cfg(2'h1, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0, 1'h1, 4'h1, 1'h1);
    cfg(2'h0, 1'h1, 1'h1, 2'h2, 1'h0, 1'h0, 1'h0, 4'h8, 1'h0);
    cfg(2'h0, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 1'h1, 4'h8, 1'h0);
    per(1'h0, 4'h0, 32);
    per(1'h1, 4'h0, 128);
    per(1'h0, 4'h1, 64);
    for (int i = 0; i < 4; i++) begin
      win(2'(i), op[i] - 20, 1'h1);
      win(2'(i), op[i] + 20, 1'h0);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
